// File: rtl/payload_pkg.sv
// What this block does
// - Bit 31 of header dword 7 is set only when the thread matched the debug criteria.
// - Bits 23:0 of dword 6 carry a thread identifier unique over a bounded period.
// - Bits 31:10 of dword 5 carry the scratch offset in 1 KB units.
// - Bits 3:0 of dword 5 carry a slot tag unique among outstanding threads.
// - Bits 31:5 of dword 4 carry the binding table offset, bits 4:0 zero.
// - Bits 31:5 of dword 3 carry the sampler state offset in 32-byte units.
// - Bits 3:0 of dword 3 carry the scratch size exponent, legal 0 to 11.
// - All of dword 2 is driven to zero.
// - Bits 8:0 of dword 0 carry the lower result handle.
// - Bits 8:0 of dword 1 carry the upper result handle.
// - Bits 24:16 of dword 0 carry the lower handle index.
package payload_pkg;

  // ---------------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------------
  localparam logic [3:0] REG_SCRATCH   = 4'h0;
  localparam logic [3:0] REG_BINDING   = 4'h1;
  localparam logic [3:0] REG_SAMPLER   = 4'h2;
  localparam logic [3:0] REG_SIZE      = 4'h3;
  localparam logic [3:0] REG_STATUS    = 4'h4;
  localparam logic [3:0] REG_THREAD_ID = 4'h5;

  // ---------------------------------------------------------------------
  // Field layout and limits
  // ---------------------------------------------------------------------
  localparam int          SNAP_BIT      = 31;
  localparam int          TID_W         = 24;
  localparam int          SLOT_W        = 4;
  localparam int          HANDLE_W      = 9;
  localparam int          INDEX_LSB     = 16;
  localparam logic [3:0]  SIZE_MAX      = 4'hB;
  localparam logic [31:0] RESET_VALUE   = 32'h0000_0000;

endpackage : payload_pkg

// File: rtl/slot_if.sv
`timescale 1ns/1ps
interface slot_if;
  logic       alloc;
  logic       release_v;
  logic [3:0] release_tag;
  logic [3:0] tag;
  logic       avail;
  modport owner (output alloc, output release_v, output release_tag,
                 input tag, input avail);
  modport pool  (input alloc, input release_v, input release_tag,
                 output tag, output avail);
endinterface : slot_if

// File: rtl/slot_pool.sv
`timescale 1ns/1ps
module slot_pool
  import payload_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  slot_if.pool     sp
);

  logic [15:0] busy_r;
  logic [15:0] busy_nxt;
  logic [3:0]  pick;
  logic        found;

  // Lowest free slot; a tag is reused only after its thread is released.
  always_comb begin
    pick  = 4'h0;
    found = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      if (!busy_r[i]) begin
        pick  = 4'(i);
        found = 1'b1;
      end
    end
  end

  always_comb begin
    busy_nxt = busy_r;
    if (sp.release_v) begin
      busy_nxt[sp.release_tag] = 1'b0;
    end
    if (sp.alloc && found) begin
      busy_nxt[pick] = 1'b1;
    end
  end

  assign sp.tag   = pick;
  assign sp.avail = found;

  always_ff @(posedge clk) begin
    if (rst) begin
      busy_r <= 16'h0000;
    end else begin
      busy_r <= busy_nxt;
    end
  end

endmodule : slot_pool

// File: rtl/vertex_thread_payload_header.sv
`timescale 1ns/1ps
module vertex_thread_payload_header
  import payload_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [3:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [31:0] rdata,
  input  wire logic        spawn_req,
  input  wire logic        debug_match,
  input  wire logic [8:0]  lower_result_handle,
  input  wire logic [8:0]  upper_result_handle,
  input  wire logic [8:0]  lower_handle_index,
  input  wire logic        retire_valid,
  input  wire logic [3:0]  retire_tag,
  output logic             spawn_busy,
  output logic             dispatch_valid,
  output logic [255:0]     header
);

  // ---------------------------------------------------------------------
  // State registers written by software, plus the size error flag and the thread id counter
  // ---------------------------------------------------------------------
  logic [21:0] scratch_off_r;
  logic [26:0] binding_off_r;
  logic [26:0] sampler_off_r;
  logic [3:0]  scratch_size_r;
  logic [23:0] thread_id_r;
  logic        size_err_r;

  wire wr_scratch = wr && (addr == REG_SCRATCH);
  wire wr_binding = wr && (addr == REG_BINDING);
  wire wr_sampler = wr && (addr == REG_SAMPLER);
  wire wr_size    = wr && (addr == REG_SIZE);
  wire size_ok    = wdata[3:0] <= SIZE_MAX;

  always_ff @(posedge clk) begin
    if (rst) begin
      scratch_off_r  <= RESET_VALUE[21:0];
      binding_off_r  <= RESET_VALUE[26:0];
      sampler_off_r  <= RESET_VALUE[26:0];
      scratch_size_r <= RESET_VALUE[3:0];
      size_err_r     <= 1'b0;
    end else begin
      if (wr_scratch) begin
        scratch_off_r <= wdata[31:10];
      end
      if (wr_binding) begin
        binding_off_r <= wdata[31:5];
      end
      if (wr_sampler) begin
        sampler_off_r <= wdata[31:5];
      end
      if (wr_size && size_ok) begin
        scratch_size_r <= wdata[3:0];
      end
      // Illegal sizes are dropped so the header never carries one.
      if (wr_size && !size_ok) begin
        size_err_r <= 1'b1;
      end else if (wr && addr == REG_STATUS && wdata[0]) begin
        size_err_r <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------------
  // Slot tag pool
  // ---------------------------------------------------------------------
  slot_if sif ();
  wire    take = spawn_req && sif.avail;

  assign sif.alloc       = take;
  assign sif.release_v   = retire_valid;
  assign sif.release_tag = retire_tag;

  slot_pool u_pool (
    .clk (clk),
    .rst (rst),
    .sp  (sif)
  );

  // ---------------------------------------------------------------------
  // Header assembly
  // ---------------------------------------------------------------------
  logic [31:0] dw [8];

  always_comb begin
    dw[0] = {7'h00, lower_handle_index, 7'h00, lower_result_handle};
    dw[0][INDEX_LSB +: HANDLE_W] = lower_handle_index;
    dw[1] = {23'h000000, upper_result_handle};
    dw[2] = 32'h0000_0000;
    dw[3] = {sampler_off_r, 1'b0, scratch_size_r};
    dw[4] = {binding_off_r, 5'h00};
    dw[5] = {scratch_off_r, 6'h00, sif.tag};
    dw[6] = {8'h00, thread_id_r};
    dw[7] = {debug_match, 31'h0000_0000};
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      dispatch_valid <= 1'b0;
      header         <= 256'h0;
      thread_id_r    <= RESET_VALUE[23:0];
      spawn_busy     <= 1'b0;
    end else begin
      dispatch_valid <= take;
      spawn_busy     <= spawn_req && !sif.avail;
      if (take) begin
        header      <= {dw[7], dw[6], dw[5], dw[4],
                        dw[3], dw[2], dw[1], dw[0]};
        thread_id_r <= thread_id_r + 24'h000001;
      end
    end
  end

  // ---------------------------------------------------------------------
  // Read port
  // ---------------------------------------------------------------------
  logic [31:0] rsel;
  always_comb begin
    unique case (addr)
      REG_SCRATCH:   rsel = {scratch_off_r, 10'h000};
      REG_BINDING:   rsel = {binding_off_r, 5'h00};
      REG_SAMPLER:   rsel = {sampler_off_r, 5'h00};
      REG_SIZE:      rsel = {28'h0000000, scratch_size_r};
      REG_STATUS:    rsel = {30'h00000000, !sif.avail, size_err_r};
      REG_THREAD_ID: rsel = {8'h00, thread_id_r};
      default:       rsel = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rdata <= 32'h0000_0000;
    end else begin
      rdata <= rd ? rsel : 32'h0000_0000;
    end
  end

endmodule : vertex_thread_payload_header

// File: testbench/eu_thread_model.sv
`timescale 1ns/1ps
module eu_thread_model (
  input wire logic         clk,
  input wire logic         stall,
  input wire logic         dispatch_valid,
  input wire logic [255:0] header,
  output logic             retire_valid = 1'b0,
  output logic [3:0]       retire_tag = 4'h0
);
  logic [3:0] q[$];
  // Idle tag lines toggle so a stale tag is never mistaken for a retire.
  always @(posedge clk) begin
    if (dispatch_valid)
      q.push_back(header[163:160]);
    retire_valid <= !stall && q.size() > 0;
    if (!stall && q.size() > 0)
      retire_tag <= q.pop_front();
    else
      retire_tag <= ~retire_tag;
  end
endmodule : eu_thread_model

// File: testbench/payload_assertions.sv
`timescale 1ns/1ps
module payload_assertions
  import payload_pkg::*;
(
  input wire logic         clk,
  input wire logic         rst,
  input wire logic         debug_match,
  input wire logic [8:0]   lower_result_handle,
  input wire logic [8:0]   upper_result_handle,
  input wire logic [8:0]   lower_handle_index,
  input wire logic         retire_valid,
  input wire logic [3:0]   retire_tag,
  input wire logic         dispatch_valid,
  input wire logic [255:0] header
);
  // -----------------------------------------------------------------
  // Shadow of issued ids and outstanding tags
  // -----------------------------------------------------------------
  logic [23:0] tid_r;
  logic [15:0] out_r;
  always_ff @(posedge clk) begin
    if (rst) begin
      tid_r <= '0;
      out_r <= '0;
    end else begin
      tid_r <= tid_r + {23'h0, dispatch_valid};
      out_r <= (out_r & ~(16'(retire_valid) << retire_tag))
             | (16'(dispatch_valid) << header[163:160]);
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  AST_SNAP: assert property (dispatch_valid |->
    header[255] == $past(debug_match)) else $error("debug flag wrong");
  AST_TID: assert property (dispatch_valid |->
    header[215:192] == tid_r) else $error("thread id not in sequence");
  AST_SLOT: assert property (dispatch_valid |->
    !out_r[header[163:160]]) else $error("slot tag still outstanding");
  AST_ZERO: assert property (dispatch_valid |->
    header[95:64] == 32'h0) else $error("dword 2 not zero");
  AST_LO: assert property (dispatch_valid |->
    header[8:0] == $past(lower_result_handle)) else $error("lower handle");
  AST_UP: assert property (dispatch_valid |->
    header[40:32] == $past(upper_result_handle)) else $error("upper handle");
  AST_IDX: assert property (dispatch_valid |->
    header[24:16] == $past(lower_handle_index)) else $error("handle index");
  AST_HOLD: assert property (!dispatch_valid |->
    $stable(header)) else $error("header moved without dispatch");
endmodule : payload_assertions

// File: testbench/testbench.sv
`timescale 1ns/1ps
module testbench;
  import payload_pkg::*;
  logic clk = 0, rst = 1, wr = 0, rd = 0, spawn_req = 0, stall = 0;
  logic debug_match = 0, retire_valid, spawn_busy, dispatch_valid;
  logic [3:0] addr = 0, retire_tag;
  logic [8:0] lower_result_handle = 0, upper_result_handle = 0;
  logic [8:0] lower_handle_index = 0;
  logic [31:0] wdata = 0, rdata;
  logic [255:0] header;
  logic [27:0] rows [3] = '{28'h0000000, 28'hFFFFFFF, 28'h5A5A5A5};
  int fail_count = 0, cmp_count = 0, tid = 0;
  always #2.5 clk = ~clk;
  vertex_thread_payload_header uut (.*);
  eu_thread_model eu (.clk, .stall, .dispatch_valid, .header,
    .retire_valid, .retire_tag);
  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task wreg(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1;
    @(posedge clk);
    wr <= 0;
  endtask : wreg
  task rreg(input logic [3:0] a, input logic [31:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1;
    @(posedge clk);
    rd <= 0;
    #1 chk(rdata, e);
  endtask : rreg
  task spawn(input logic [27:0] r, input logic [3:0] t);
    @(posedge clk);
    {debug_match, lower_result_handle, upper_result_handle,
     lower_handle_index} <= r;
    spawn_req <= 1;
    @(posedge clk);
    spawn_req <= 0;
    #1 chk({31'h0, dispatch_valid}, 32'h1);
    chk(header[255:224], {r[27], 31'h0});
    chk({8'h0, header[215:192]}, tid[23:0]);
    chk(header[191:160] & 32'hFFFFFC0F, {28'hABCDE40, t});
    chk(header[159:128], 32'h12345660);
    chk(header[127:96] & 32'hFFFFFFEF, 32'h8765432B);
    chk(header[95:64], 32'h0);
    chk(header[63:32] & 32'h1FF, {23'h0, r[17:9]});
    chk(header[31:0] & 32'h1FF01FF, {7'h0, r[8:0], 7'h0, r[26:18]});
    tid++;
  endtask : spawn
  task finish_test;
    $display("mismatches %0d compares %0d", fail_count, cmp_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : finish_test
  initial begin
    #100000;
    fail_count++;
    finish_test();
  end
  initial begin
    repeat (2) @(posedge clk);
    rst <= 0;
    #1 chk({30'h0, dispatch_valid, spawn_busy}, 32'h0);
    wreg(REG_SCRATCH, 32'hABCDE7FF);
    wreg(REG_BINDING, 32'h1234567F);
    wreg(REG_SAMPLER, 32'h8765433F);
    wreg(REG_SIZE, 32'hB);
    wreg(REG_SIZE, 32'hC);
    rreg(REG_SIZE, 32'hB);
    rreg(REG_STATUS, 32'h1);
    wreg(REG_STATUS, 32'h1);
    rreg(REG_STATUS, 32'h0);
    rreg(4'hF, 32'h0);
    for (int i = 0; i < 3; i++) begin
      spawn(rows[i], 4'h0);
      repeat (3) @(posedge clk);
    end
    rreg(REG_THREAD_ID, 32'h3);
    @(posedge clk);
    stall <= 1;
    for (int i = 0; i < 16; i++)
      spawn(rows[1], 4'(i));
    @(posedge clk);
    spawn_req <= 1;
    @(posedge clk);
    spawn_req <= 0;
    #1 chk({30'h0, spawn_busy, dispatch_valid}, 32'h2);
    rreg(REG_STATUS, 32'h2);
    @(posedge clk);
    stall <= 0;
    repeat (20) @(posedge clk);
    spawn(rows[2], 4'h0);
    finish_test();
  end
endmodule : testbench
bind vertex_thread_payload_header payload_assertions chk_i (.*);
